// ### rtl/dmm_top.v
// Contract
// (RULE1) 128 byte RAM also holds stack
// (RULE2) 0C0H..0FFH decode as control registers
// (RULE3) software avoids unimplemented window addresses
// (RULE4) software writes write-only registers bytewise
// (RULE5) bit ops only on bit-addressable registers
// (RULE6) D1H reads count or capture, writes compare
// (RULE7) D3H compare/period, D4H count/capture/duty
// (RULE8) ECH reads interval count, writes divider
// (RULE9) push return address before control transfer
// (RULE10) return restores PC; interrupt return adds flags
// (RULE11) stack pointer drops after save, rises before restore
// (RULE12) register mode touches no memory
// (RULE13) immediate mode uses second byte as data
// (RULE14) absolute: second byte low, third high
// (RULE15) X indexed uses X as address
// (RULE16) auto-increment uses X then bumps X; the code bumps X only for read and write, not for bit set/clear
// (RULE17) dp plus X wraps in page
// (RULE18) dp plus Y wraps in page
// (RULE19) absolute plus Y spans whole space
// (RULE20) pointer at dp plus X, then X plus one
// (RULE21) pointer at dp, plus Y for address
// (RULE22) absolute indirect loads PC from pointer
// (RULE23) stack in 00H..7FH, 8-bit stack pointer
// (RULE24) software sets stack pointer before calls
// (RULE25) direct page addresses wrap within page zero
`timescale 1ns/1ps
`default_nettype none
`include "dmm_consts.vh"
module dmm_top (
	input wire I_MCLK,
	input wire I_NRST,
	input wire I_CE,
	input wire I_START,
	input wire [3:0] I_MODE,
	input wire [1:0] I_KIND,
	input wire [2:0] I_BIT,
	input wire [7:0] I_OP1,
	input wire [7:0] I_OP2,
	input wire [7:0] I_X,
	input wire [7:0] I_Y,
	input wire [7:0] I_WDATA,
	input wire I_STK_START,
	input wire [1:0] I_STK_KIND,
	input wire [15:0] I_PC,
	input wire [7:0] I_PSW,
	input wire I_SP_WR,
	input wire [7:0] I_SP_WDATA,
	input wire [7:0] I_PA_PIN,
	input wire [7:0] I_PB_PIN,
	input wire [7:0] I_PC_PIN,
	input wire [7:0] I_PD_PIN,
	input wire [7:0] I_T0_COUNT,
	input wire [7:0] I_T0_CAPTURE,
	input wire [7:0] I_T1_COUNT,
	input wire [7:0] I_T1_CAPTURE,
	input wire [7:0] I_ADC_RESULT,
	input wire [7:0] I_ITV_COUNT,
	input wire [7:0] I_WDT_COUNT,
	input wire [7:0] I_IRQ_SET_H,
	input wire [7:0] I_IRQ_SET_L,
	output reg O_BUSY,
	output reg O_DONE,
	output reg [7:0] O_RDATA,
	output reg [15:0] O_EA,
	output reg O_EXT,
	output reg O_X_INC,
	output reg [7:0] O_SP,
	output reg O_PC_LOAD,
	output reg [15:0] O_PC,
	output reg O_PSW_LOAD,
	output reg [7:0] O_PSW,
	output reg [7:0] O_PORT_A_DATA,
	output reg [7:0] O_PORT_A_DIR,
	output reg [7:0] O_PORT_B_DATA,
	output reg [7:0] O_PORT_B_DIR,
	output reg [7:0] O_PORT_C_DATA,
	output reg [7:0] O_PORT_C_DIR,
	output reg [7:0] O_PORT_D_DATA,
	output reg [7:0] O_PORT_D_DIR,
	output reg [7:0] O_PORT_A_FUNC,
	output reg [7:0] O_PORT_B_FUNC,
	output reg [7:0] O_PULLUP_SEL,
	output reg [7:0] O_TIMER0_MODE,
	output reg [7:0] O_TIMER0_COMPARE,
	output reg [7:0] O_TIMER1_MODE,
	output reg [7:0] O_TIMER1_COMPARE,
	output reg [7:0] O_PWM_PERIOD,
	output reg [7:0] O_PWM_DUTY,
	output reg [7:0] O_PWM_HIGH,
	output reg [7:0] O_BUZZER_CTRL,
	output reg [7:0] O_IRQ_EN_H,
	output reg [7:0] O_IRQ_EN_L,
	output reg [7:0] O_IRQ_REQ_H,
	output reg [7:0] O_IRQ_REQ_L,
	output reg [7:0] O_IRQ_EDGE_SEL,
	output reg [7:0] O_ADC_MODE,
	output reg [7:0] O_CLK_DIV_CTRL,
	output reg [7:0] O_WDT_RELOAD,
	output reg O_WDT_RELOAD_WR,
	output reg [7:0] O_POWER_FAIL
);
	localparam [5:0] S_IDLE = 6'b000001;
	localparam [5:0] S_PLO = 6'b000010;
	localparam [5:0] S_PHI = 6'b000100;
	localparam [5:0] S_ACC = 6'b001000;
	localparam [5:0] S_PUSH = 6'b010000;
	localparam [5:0] S_POP = 6'b100000;

	reg [5:0] state;
	reg [3:0] mode;
	reg [1:0] kind;
	reg [2:0] bit_sel;
	reg [7:0] op1;
	reg [7:0] op2;
	reg [7:0] x_val;
	reg [7:0] y_val;
	reg [7:0] wdata;
	reg [15:0] ptr;
	reg [1:0] stk_kind;
	reg [1:0] stk_cnt;
	reg [15:0] pc_save;
	reg [7:0] psw_save;
	reg [31:0] pin_meta;
	reg [31:0] pin_sync;
	reg [7:0] mem_addr;
	reg mem_we;
	reg [1:0] mem_kind;
	reg [7:0] mem_wdata;
	reg [7:0] rd;
	reg [7:0] wr_byte;
	wire [7:0] ptr_addr;
	wire [15:0] ea;
	wire [7:0] ram_q;
	wire eff_we;
	wire pwm_mode;

	// bit set/clear is only honoured on bit-addressable registers
	function is_bit_reg;
		input [7:0] a;
		begin
			is_bit_reg = (a == `DMM_A_PA) || (a == `DMM_A_PB) || (a == `DMM_A_PC) ||
				(a == `DMM_A_PD) || (a == `DMM_A_T0_MODE) || (a == `DMM_A_T1_MODE) ||
				(a == `DMM_A_T1_DATA) || (a == `DMM_A_IEN_H) || (a == `DMM_A_IEN_L) ||
				(a == `DMM_A_IRQ_H) || (a == `DMM_A_IRQ_L) || (a == `DMM_A_EDGE) ||
				(a == `DMM_A_ADC_MODE) || (a == `DMM_A_PFAIL) || (a < `DMM_RAM_TOP);
		end
	endfunction

	function is_ptr_mode;
		input [3:0] m;
		begin
			is_ptr_mode = (m == `DMM_MD_XIND) || (m == `DMM_MD_INDY) ||
				(m == `DMM_MD_DPIND) || (m == `DMM_MD_ABSIND);
		end
	endfunction

	assign pwm_mode = O_TIMER1_MODE[`DMM_B_PWM_EN];
	assign eff_we = mem_we && ((mem_kind == `DMM_K_WRITE) || is_bit_reg(mem_addr)); // RULE5

	dmm_agu u_agu (
		.i_mode(mode),
		.i_op1(op1),
		.i_op2(op2),
		.i_x(x_val),
		.i_y(y_val),
		.i_ptr(ptr),
		.o_ptr_addr(ptr_addr),
		.o_ea(ea)
	);

	dmm_ram #(
		.WIDTH(8),
		.DEPTH(128),
		.AW(7)
	) u_ram (
		.i_clk(I_MCLK),
		.i_ce(I_CE),
		.i_we(eff_we && (mem_addr < `DMM_RAM_TOP)), // RULE1
		.i_addr(mem_addr[6:0]),
		.i_wdata(wr_byte),
		.o_rdata(ram_q)
	);

	// port pins come from outside the clock domain
	always @(posedge I_MCLK) begin
		if (I_CE) begin
			pin_meta <= {I_PD_PIN, I_PC_PIN, I_PB_PIN, I_PA_PIN};
			pin_sync <= pin_meta;
		end
	end

	// memory port steering per sequencer state
	always @* begin
		mem_addr = 8'h00;
		mem_we = 1'b0;
		mem_kind = kind;
		mem_wdata = wdata;
		case (state)
			S_PLO: mem_addr = ptr_addr;
			S_PHI: mem_addr = ptr_addr + 8'h01; // RULE20 RULE21 RULE25
			S_ACC: begin
				mem_addr = ea[7:0];
				mem_we = (kind != `DMM_K_READ) && (ea[15:8] == 8'h00);
			end
			S_PUSH: begin
				mem_addr = O_SP; // RULE11
				mem_we = 1'b1;
				mem_kind = `DMM_K_WRITE;
				if (stk_cnt == `DMM_N_THREE) begin
					mem_wdata = pc_save[15:8];
				end else if (stk_cnt == `DMM_N_TWO) begin
					mem_wdata = (stk_kind == `DMM_S_INT) ? pc_save[7:0] : pc_save[15:8];
				end else begin
					mem_wdata = (stk_kind == `DMM_S_INT) ? psw_save : pc_save[7:0];
				end
			end
			S_POP: mem_addr = O_SP + 8'h01; // RULE11
			default: mem_addr = 8'h00;
		endcase
	end

	// read decode; unimplemented locations read as zero
	always @* begin
		rd = 8'h00;
		if (mem_addr < `DMM_RAM_TOP) begin
			rd = ram_q;
		end else if (mem_addr < `DMM_WIN_BASE) begin
			rd = 8'h00;
		end else if (mem_addr == `DMM_A_PA) begin // RULE2
			rd = pin_sync[7:0];
		end else if (mem_addr == `DMM_A_PB) begin
			rd = pin_sync[15:8];
		end else if (mem_addr == `DMM_A_PC) begin
			rd = pin_sync[23:16];
		end else if (mem_addr == `DMM_A_PD) begin
			rd = pin_sync[31:24];
		end else if (mem_addr == `DMM_A_T0_MODE) begin
			rd = O_TIMER0_MODE;
		end else if (mem_addr == `DMM_A_T0_DATA) begin
			rd = O_TIMER0_MODE[`DMM_B_CAP0] ? I_T0_CAPTURE : I_T0_COUNT; // RULE6
		end else if (mem_addr == `DMM_A_T1_MODE) begin
			rd = O_TIMER1_MODE;
		end else if (mem_addr == `DMM_A_T1_DATA) begin
			if (pwm_mode) begin // RULE7
				rd = O_PWM_DUTY;
			end else begin
				rd = O_TIMER1_MODE[`DMM_B_CAP1] ? I_T1_CAPTURE : I_T1_COUNT;
			end
		end else if (mem_addr == `DMM_A_IEN_H) begin
			rd = O_IRQ_EN_H;
		end else if (mem_addr == `DMM_A_IEN_L) begin
			rd = O_IRQ_EN_L;
		end else if (mem_addr == `DMM_A_IRQ_H) begin
			rd = O_IRQ_REQ_H;
		end else if (mem_addr == `DMM_A_IRQ_L) begin
			rd = O_IRQ_REQ_L;
		end else if (mem_addr == `DMM_A_EDGE) begin
			rd = O_IRQ_EDGE_SEL;
		end else if (mem_addr == `DMM_A_ADC_MODE) begin
			rd = O_ADC_MODE;
		end else if (mem_addr == `DMM_A_ADC_RES) begin
			rd = I_ADC_RESULT;
		end else if (mem_addr == `DMM_A_ITV) begin
			rd = I_ITV_COUNT; // RULE8
		end else if (mem_addr == `DMM_A_WDT) begin
			rd = I_WDT_COUNT;
		end else if (mem_addr == `DMM_A_PFAIL) begin
			rd = O_POWER_FAIL;
		end
	end

	always @* begin
		case (mem_kind)
			`DMM_K_BSET: wr_byte = rd | (8'h01 << bit_sel);
			`DMM_K_BCLR: wr_byte = rd & ~(8'h01 << bit_sel);
			default: wr_byte = mem_wdata;
		endcase
	end

	// control register file
	always @(posedge I_MCLK) begin
		if (!I_NRST) begin
			O_PORT_A_DATA <= `DMM_RST_ZERO;
			O_PORT_A_DIR <= `DMM_RST_ZERO;
			O_PORT_B_DATA <= `DMM_RST_ZERO;
			O_PORT_B_DIR <= `DMM_RST_ZERO;
			O_PORT_C_DATA <= `DMM_RST_ZERO;
			O_PORT_C_DIR <= `DMM_RST_ZERO;
			O_PORT_D_DATA <= `DMM_RST_ZERO;
			O_PORT_D_DIR <= `DMM_RST_ZERO;
			O_PORT_A_FUNC <= `DMM_RST_ZERO;
			O_PORT_B_FUNC <= `DMM_RST_ZERO;
			O_PULLUP_SEL <= `DMM_RST_ZERO;
			O_TIMER0_MODE <= `DMM_RST_ZERO;
			O_TIMER0_COMPARE <= `DMM_RST_ONES;
			O_TIMER1_MODE <= `DMM_RST_ZERO;
			O_TIMER1_COMPARE <= `DMM_RST_ONES;
			O_PWM_PERIOD <= `DMM_RST_ONES;
			O_PWM_DUTY <= `DMM_RST_ZERO;
			O_PWM_HIGH <= `DMM_RST_ZERO;
			O_BUZZER_CTRL <= `DMM_RST_ONES;
			O_IRQ_EN_H <= `DMM_RST_ZERO;
			O_IRQ_EN_L <= `DMM_RST_ZERO;
			O_IRQ_REQ_H <= `DMM_RST_ZERO;
			O_IRQ_REQ_L <= `DMM_RST_ZERO;
			O_IRQ_EDGE_SEL <= `DMM_RST_ZERO;
			O_ADC_MODE <= `DMM_RST_ADC_MODE;
			O_CLK_DIV_CTRL <= `DMM_RST_CKDIV;
			O_WDT_RELOAD <= `DMM_RST_WDT;
			O_WDT_RELOAD_WR <= 1'b0;
			O_POWER_FAIL <= `DMM_RST_PFAIL;
		end else if (I_CE) begin
			O_WDT_RELOAD_WR <= 1'b0;
			// a peripheral event in the same cycle as a software clear survives
			O_IRQ_REQ_H <= ((eff_we && (mem_addr == `DMM_A_IRQ_H)) ? wr_byte : O_IRQ_REQ_H)
				& `DMM_M_HIGH4 | (I_IRQ_SET_H & `DMM_M_HIGH4);
			O_IRQ_REQ_L <= ((eff_we && (mem_addr == `DMM_A_IRQ_L)) ? wr_byte : O_IRQ_REQ_L)
				& `DMM_M_HIGH3 | (I_IRQ_SET_L & `DMM_M_HIGH3);
			if (eff_we) begin
				if (mem_addr == `DMM_A_PA) begin
					O_PORT_A_DATA <= wr_byte;
				end else if (mem_addr == `DMM_A_PA_DIR) begin
					O_PORT_A_DIR <= wr_byte;
				end else if (mem_addr == `DMM_A_PB) begin
					O_PORT_B_DATA <= wr_byte;
				end else if (mem_addr == `DMM_A_PB_DIR) begin
					O_PORT_B_DIR <= wr_byte;
				end else if (mem_addr == `DMM_A_PC) begin
					O_PORT_C_DATA <= wr_byte;
				end else if (mem_addr == `DMM_A_PC_DIR) begin
					O_PORT_C_DIR <= wr_byte & `DMM_M_LOW2;
				end else if (mem_addr == `DMM_A_PD) begin
					O_PORT_D_DATA <= wr_byte;
				end else if (mem_addr == `DMM_A_PD_DIR) begin
					O_PORT_D_DIR <= wr_byte & `DMM_M_LOW4;
				end else if (mem_addr == `DMM_A_PA_FUNC) begin
					O_PORT_A_FUNC <= wr_byte;
				end else if (mem_addr == `DMM_A_PB_FUNC) begin
					O_PORT_B_FUNC <= wr_byte;
				end else if (mem_addr == `DMM_A_PULLUP) begin
					O_PULLUP_SEL <= wr_byte & `DMM_M_LOW4;
				end else if (mem_addr == `DMM_A_T0_MODE) begin
					O_TIMER0_MODE <= wr_byte & `DMM_M_LOW6;
				end else if (mem_addr == `DMM_A_T0_DATA) begin
					O_TIMER0_COMPARE <= wr_byte; // RULE6
				end else if (mem_addr == `DMM_A_T1_MODE) begin
					O_TIMER1_MODE <= wr_byte;
				end else if (mem_addr == `DMM_A_T1_CMP) begin
					if (pwm_mode) begin // RULE7
						O_PWM_PERIOD <= wr_byte;
					end else begin
						O_TIMER1_COMPARE <= wr_byte;
					end
				end else if (mem_addr == `DMM_A_T1_DATA) begin
					if (pwm_mode) begin // RULE7
						O_PWM_DUTY <= wr_byte;
					end
				end else if (mem_addr == `DMM_A_PWM_HIGH) begin
					O_PWM_HIGH <= wr_byte & `DMM_M_LOW4;
				end else if (mem_addr == `DMM_A_BUZZER) begin
					O_BUZZER_CTRL <= wr_byte;
				end else if (mem_addr == `DMM_A_IEN_H) begin
					O_IRQ_EN_H <= wr_byte & `DMM_M_HIGH4;
				end else if (mem_addr == `DMM_A_IEN_L) begin
					O_IRQ_EN_L <= wr_byte & `DMM_M_HIGH3;
				end else if (mem_addr == `DMM_A_EDGE) begin
					O_IRQ_EDGE_SEL <= wr_byte & `DMM_M_LOW4;
				end else if (mem_addr == `DMM_A_ADC_MODE) begin
					O_ADC_MODE <= wr_byte & `DMM_M_LOW6;
				end else if (mem_addr == `DMM_A_ITV) begin
					O_CLK_DIV_CTRL <= wr_byte & `DMM_M_LOW7; // RULE8
				end else if (mem_addr == `DMM_A_WDT) begin
					O_WDT_RELOAD <= wr_byte;
					O_WDT_RELOAD_WR <= 1'b1;
				end else if (mem_addr == `DMM_A_PFAIL) begin
					O_POWER_FAIL <= wr_byte & `DMM_M_LOW4;
				end
			end
		end
	end

	// operand and stack sequencer
	always @(posedge I_MCLK) begin
		if (!I_NRST) begin
			state <= S_IDLE;
			mode <= `DMM_MD_REG;
			kind <= `DMM_K_READ;
			bit_sel <= 3'h0;
			op1 <= 8'h00;
			op2 <= 8'h00;
			x_val <= 8'h00;
			y_val <= 8'h00;
			wdata <= 8'h00;
			ptr <= 16'h0000;
			stk_kind <= `DMM_S_CALL;
			stk_cnt <= 2'h0;
			pc_save <= 16'h0000;
			psw_save <= 8'h00;
			O_SP <= 8'h00; // RULE23
			O_BUSY <= 1'b0;
			O_DONE <= 1'b0;
			O_RDATA <= 8'h00;
			O_EA <= 16'h0000;
			O_EXT <= 1'b0;
			O_X_INC <= 1'b0;
			O_PC_LOAD <= 1'b0;
			O_PC <= 16'h0000;
			O_PSW_LOAD <= 1'b0;
			O_PSW <= 8'h00;
		end else if (I_CE) begin
			O_DONE <= 1'b0;
			O_X_INC <= 1'b0;
			O_PC_LOAD <= 1'b0;
			O_PSW_LOAD <= 1'b0;
			case (state)
				S_IDLE: begin
					O_EXT <= 1'b0;
					if (I_SP_WR) begin
						O_SP <= I_SP_WDATA; // RULE24
					end else if (I_STK_START) begin
						stk_kind <= I_STK_KIND;
						pc_save <= I_PC;
						psw_save <= I_PSW;
						O_BUSY <= 1'b1;
						if (I_STK_KIND == `DMM_S_CALL) begin // RULE9
							stk_cnt <= `DMM_N_TWO;
							state <= S_PUSH;
						end else if (I_STK_KIND == `DMM_S_INT) begin
							stk_cnt <= `DMM_N_THREE;
							state <= S_PUSH;
						end else if (I_STK_KIND == `DMM_S_RET) begin // RULE10
							stk_cnt <= `DMM_N_TWO;
							state <= S_POP;
						end else begin
							stk_cnt <= `DMM_N_THREE;
							state <= S_POP;
						end
					end else if (I_START) begin
						mode <= I_MODE;
						kind <= I_KIND;
						bit_sel <= I_BIT;
						op1 <= I_OP1;
						op2 <= I_OP2;
						x_val <= I_X;
						y_val <= I_Y;
						wdata <= I_WDATA;
						if (I_MODE == `DMM_MD_REG) begin
							O_DONE <= 1'b1; // RULE12
						end else if (I_MODE == `DMM_MD_IMM) begin
							O_RDATA <= I_OP1; // RULE13
							O_DONE <= 1'b1;
						end else if ((I_MODE == `DMM_MD_ABSIND) && (I_OP2 != 8'h00)) begin
							// pointer outside the data space cannot be fetched here
							O_EA <= {I_OP2, I_OP1};
							O_EXT <= 1'b1;
							O_DONE <= 1'b1;
						end else begin
							O_BUSY <= 1'b1;
							state <= is_ptr_mode(I_MODE) ? S_PLO : S_ACC;
						end
					end
				end
				S_PLO: begin
					ptr[7:0] <= rd;
					state <= S_PHI;
				end
				S_PHI: begin
					ptr[15:8] <= rd;
					if ((mode == `DMM_MD_DPIND) || (mode == `DMM_MD_ABSIND)) begin
						O_EA <= {rd, ptr[7:0]}; // RULE22
						O_DONE <= 1'b1;
						O_BUSY <= 1'b0;
						state <= S_IDLE;
					end else begin
						state <= S_ACC;
					end
				end
				S_ACC: begin
					O_EA <= ea;
					O_EXT <= (ea[15:8] != 8'h00);
					if ((kind == `DMM_K_READ) && (ea[15:8] == 8'h00)) begin
						O_RDATA <= rd;
					end
					O_X_INC <= (mode == `DMM_MD_XINC) && (kind <= `DMM_K_WRITE); // RULE16
					O_DONE <= 1'b1;
					O_BUSY <= 1'b0;
					state <= S_IDLE;
				end
				S_PUSH: begin
					O_SP <= O_SP - 8'h01; // RULE11
					stk_cnt <= stk_cnt - 2'h1;
					if (stk_cnt == 2'h0) begin
						O_DONE <= 1'b1; // RULE9
						O_BUSY <= 1'b0;
						state <= S_IDLE;
					end
				end
				S_POP: begin
					O_SP <= O_SP + 8'h01; // RULE11
					stk_cnt <= stk_cnt - 2'h1;
					if (stk_cnt == `DMM_N_THREE) begin
						O_PSW <= rd;
					end else if (stk_cnt == `DMM_N_TWO) begin
						O_PC[7:0] <= rd;
					end else begin
						O_PC[15:8] <= rd;
						O_PC_LOAD <= 1'b1; // RULE10
						O_PSW_LOAD <= (stk_kind == `DMM_S_INTERRUPT_RETURN_OP);
						O_DONE <= 1'b1;
						O_BUSY <= 1'b0;
						state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end
endmodule // dmm_top
`default_nettype wire

// ### rtl/dmm_consts.vh
`ifndef DMM_CONSTS_VH
`define DMM_CONSTS_VH
// data space layout
`define DMM_RAM_TOP 8'h80
`define DMM_WIN_BASE 8'hc0
// control window offsets
`define DMM_A_PA 8'hc0
`define DMM_A_PA_DIR 8'hc1
`define DMM_A_PB 8'hc2
`define DMM_A_PB_DIR 8'hc3
`define DMM_A_PC 8'hc4
`define DMM_A_PC_DIR 8'hc5
`define DMM_A_PD 8'hc6
`define DMM_A_PD_DIR 8'hc7
`define DMM_A_PA_FUNC 8'hca
`define DMM_A_PB_FUNC 8'hcb
`define DMM_A_PULLUP 8'hcc
`define DMM_A_T0_MODE 8'hd0
`define DMM_A_T0_DATA 8'hd1
`define DMM_A_T1_MODE 8'hd2
`define DMM_A_T1_CMP 8'hd3
`define DMM_A_T1_DATA 8'hd4
`define DMM_A_PWM_HIGH 8'hd5
`define DMM_A_BUZZER 8'hde
`define DMM_A_IEN_H 8'he2
`define DMM_A_IEN_L 8'he3
`define DMM_A_IRQ_H 8'he4
`define DMM_A_IRQ_L 8'he5
`define DMM_A_EDGE 8'he6
`define DMM_A_ADC_MODE 8'hea
`define DMM_A_ADC_RES 8'heb
`define DMM_A_ITV 8'hec
`define DMM_A_WDT 8'hed
`define DMM_A_PFAIL 8'hef
// reset values
`define DMM_RST_ZERO 8'h00
`define DMM_RST_ONES 8'hff
`define DMM_RST_ADC_MODE 8'h01
`define DMM_RST_CKDIV 8'h17
`define DMM_RST_WDT 8'h7f
`define DMM_RST_PFAIL 8'h04
// implemented-bit masks
`define DMM_M_LOW2 8'h03
`define DMM_M_LOW4 8'h0f
`define DMM_M_LOW6 8'h3f
`define DMM_M_LOW7 8'h7f
`define DMM_M_HIGH4 8'hf0
`define DMM_M_HIGH3 8'he0
// timer mode bits
`define DMM_B_CAP0 5
`define DMM_B_PWM_EN 5
`define DMM_B_CAP1 4
// addressing modes
`define DMM_MD_REG 4'h0
`define DMM_MD_IMM 4'h1
`define DMM_MD_DP 4'h2
`define DMM_MD_ABS 4'h3
`define DMM_MD_XIDX 4'h4
`define DMM_MD_XINC 4'h5
`define DMM_MD_DPX 4'h6
`define DMM_MD_DPY 4'h7
`define DMM_MD_ABSY 4'h8
`define DMM_MD_XIND 4'h9
`define DMM_MD_INDY 4'ha
`define DMM_MD_DPIND 4'hb
`define DMM_MD_ABSIND 4'hc
// access kinds
`define DMM_K_READ 2'h0
`define DMM_K_WRITE 2'h1
`define DMM_K_BSET 2'h2
`define DMM_K_BCLR 2'h3
// stack operations and their byte counts less one
`define DMM_S_CALL 2'h0
`define DMM_S_INT 2'h1
`define DMM_S_RET 2'h2
`define DMM_S_INTERRUPT_RETURN_OP 2'h3
`define DMM_N_TWO 2'h1
`define DMM_N_THREE 2'h2
`endif

// ### rtl/dmm_ram.v
`timescale 1ns/1ps
`default_nettype none
module dmm_ram #(
	parameter WIDTH = 8,
	parameter DEPTH = 128,
	parameter AW = 7
) (
	input wire i_clk,
	input wire i_ce,
	input wire i_we,
	input wire [AW-1:0] i_addr,
	input wire [WIDTH-1:0] i_wdata,
	output wire [WIDTH-1:0] o_rdata
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];

	// contents are not cleared at reset, software owns initialisation
	always @(posedge i_clk) begin
		if (i_ce && i_we) begin
			mem[i_addr] <= i_wdata;
		end
	end
	assign o_rdata = mem[i_addr];
endmodule // dmm_ram
`default_nettype wire

// ### rtl/dmm_agu.v
`timescale 1ns/1ps
`default_nettype none
`include "dmm_consts.vh"
module dmm_agu (
	input wire [3:0] i_mode,
	input wire [7:0] i_op1,
	input wire [7:0] i_op2,
	input wire [7:0] i_x,
	input wire [7:0] i_y,
	input wire [15:0] i_ptr,
	output reg [7:0] o_ptr_addr,
	output reg [15:0] o_ea
);
	// 8-bit sums wrap inside page zero
	always @* begin
		o_ptr_addr = i_op1;
		o_ea = 16'h0000;
		case (i_mode)
			`DMM_MD_DP: o_ea = {8'h00, i_op1};
			`DMM_MD_ABS: o_ea = {i_op2, i_op1}; // RULE14
			`DMM_MD_XIDX: o_ea = {8'h00, i_x}; // RULE15
			`DMM_MD_XINC: o_ea = {8'h00, i_x}; // RULE16
			`DMM_MD_DPX: o_ea = {8'h00, i_op1 + i_x}; // RULE17 RULE25
			`DMM_MD_DPY: o_ea = {8'h00, i_op1 + i_y}; // RULE18 RULE25
			`DMM_MD_ABSY: o_ea = {i_op2, i_op1} + {8'h00, i_y}; // RULE19
			`DMM_MD_XIND: begin
				o_ptr_addr = i_op1 + i_x; // RULE20
				o_ea = i_ptr;
			end
			`DMM_MD_INDY: o_ea = i_ptr + {8'h00, i_y}; // RULE21
			`DMM_MD_DPIND: o_ea = i_ptr;
			`DMM_MD_ABSIND: o_ea = i_ptr; // RULE22
			default: o_ea = 16'h0000;
		endcase
	end
endmodule // dmm_agu
`default_nettype wire

// ### testbench/dmm_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmm_consts.vh"
module dmm_chk (
	input wire I_MCLK,
	input wire I_NRST,
	input wire I_CE,
	input wire I_START,
	input wire [3:0] I_MODE,
	input wire [1:0] I_KIND,
	input wire [7:0] I_OP1,
	input wire [7:0] I_X,
	input wire [7:0] I_Y,
	input wire I_STK_START,
	input wire [1:0] I_STK_KIND,
	input wire I_SP_WR,
	input wire O_BUSY,
	input wire O_DONE,
	input wire [7:0] O_RDATA,
	input wire [15:0] O_EA,
	input wire O_X_INC,
	input wire [7:0] O_SP,
	input wire O_PC_LOAD,
	input wire O_PSW_LOAD
);
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_NRST);
	// only quiet cycles count, so a refused request never arms a property
	wire idle = I_CE && !O_BUSY && !O_DONE && !I_SP_WR;
	wire go = idle && I_START && !I_STK_START;
	wire sgo = idle && I_STK_START;
	logic [7:0] sp0;
	always @(posedge I_MCLK) if (sgo) sp0 <= O_SP;
	property p_imm; go && I_MODE == `DMM_MD_IMM |=> O_DONE && O_RDATA == $past(I_OP1); endproperty
	property p_reg; go && I_MODE == `DMM_MD_REG |=> O_DONE && $stable(O_EA); endproperty
	property p_dp;
		go && I_MODE == `DMM_MD_DP |=> O_BUSY ##1 O_DONE && O_EA == {8'h00, $past(I_OP1, 2)};
	endproperty
	property p_dpx;
		go && I_MODE == `DMM_MD_DPX |=> ##1 O_EA == {8'h00, 8'($past(I_OP1, 2) + $past(I_X, 2))};
	endproperty
	property p_dpy;
		go && I_MODE == `DMM_MD_DPY |=> ##1 O_EA == {8'h00, 8'($past(I_OP1, 2) + $past(I_Y, 2))};
	endproperty
	property p_xinc; go && I_MODE == `DMM_MD_XINC && !I_KIND[1] |=> ##[1:2] O_X_INC; endproperty
	property p_call;
		sgo && I_STK_KIND == `DMM_S_CALL |-> ##[2:6] O_DONE && O_SP == 8'(sp0 - 8'd2);
	endproperty
	property p_ret;
		sgo && I_STK_KIND == `DMM_S_RET |-> ##[2:6] O_PC_LOAD && !O_PSW_LOAD && O_SP == 8'(sp0 + 8'd2);
	endproperty
	property p_interrupt_return_op;
		sgo && I_STK_KIND == `DMM_S_INTERRUPT_RETURN_OP |-> ##[2:6] O_PSW_LOAD && O_SP == 8'(sp0 + 8'd3);
	endproperty
	a_imm: assert property (p_imm) else $error("immediate data");
	a_reg: assert property (p_reg) else $error("register mode touched memory");
	a_dp: assert property (p_dp) else $error("direct page address");
	a_dpx: assert property (p_dpx) else $error("dp plus x address");
	a_dpy: assert property (p_dpy) else $error("dp plus y address");
	a_xinc: assert property (p_xinc) else $error("no x increment");
	a_call: assert property (p_call) else $error("call push");
	a_ret: assert property (p_ret) else $error("return pop");
	a_interrupt_return_op: assert property (p_interrupt_return_op) else $error("interrupt return pop");
	c_call: cover property (sgo && I_STK_KIND == `DMM_S_CALL);
	c_interrupt_return_op: cover property (O_PSW_LOAD);
	c_xinc: cover property (O_X_INC);
endmodule // dmm_chk
`default_nettype wire

// ### testbench/dmm_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmm_cpu_model #(
	parameter logic [7:0] INIT_SP = 8'h7f
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_x_inc,
	input wire logic i_x_ld,
	input wire logic [7:0] i_x_val,
	output logic o_sp_wr,
	output logic [7:0] o_sp_wdata,
	output logic [7:0] o_x
);
	logic [1:0] n;
	assign o_sp_wdata = INIT_SP;
	// falling edge keeps every change away from the block's sampling edge
	always @(negedge i_clk) begin
		o_sp_wr <= 1'b0;
		if (!i_rst_n) begin
			n <= 2'd0;
			o_x <= 8'h00;
		end else if (n != 2'd3) begin
			n <= n + 2'd1;
			o_sp_wr <= (n == 2'd1);
		end
		if (i_x_ld) begin
			o_x <= i_x_val;
		end else if (i_x_inc) begin
			o_x <= o_x + 8'd1;
		end
	end
endmodule // dmm_cpu_model
`default_nettype wire

// ### testbench/dmm_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmm_consts.vh"
module dmm_top_bench;
	logic I_MCLK, O_BUSY, O_DONE, O_EXT, O_X_INC, O_PC_LOAD, O_PSW_LOAD, O_WDT_RELOAD_WR, I_SP_WR;
	logic I_NRST = 1'b0, I_CE = 1'b1, I_START = 1'b0, I_STK_START = 1'b0, xl = 1'b0;
	logic [3:0] I_MODE = 4'h0;
	logic [2:0] I_BIT = 3'h0;
	logic [1:0] I_KIND = 2'h0, I_STK_KIND = 2'h0;
	logic [15:0] I_PC = 16'h0000, O_EA, O_PC;
	logic [7:0] I_OP1 = 8'h00, I_OP2 = 8'h00, I_Y = 8'h00, I_WDATA = 8'h00, I_PSW = 8'h00;
	logic [7:0] I_PA_PIN = 8'h96, I_PB_PIN = 8'h15, I_PC_PIN = 8'h02, I_PD_PIN = 8'h09;
	logic [7:0] I_T0_COUNT = 8'h41, I_T0_CAPTURE = 8'h42, I_T1_COUNT = 8'h43;
	logic [7:0] I_T1_CAPTURE = 8'h44, I_ITV_COUNT = 8'h45, I_ADC_RESULT = 8'h46;
	logic [7:0] I_WDT_COUNT = 8'h27, I_IRQ_SET_H = 8'h00, I_IRQ_SET_L = 8'h00, xv, I_X;
	logic [7:0] I_SP_WDATA, O_RDATA, O_SP, O_PSW, O_PORT_A_DATA, O_PORT_A_DIR, O_PORT_B_DATA;
	logic [7:0] O_PORT_B_DIR, O_PORT_C_DATA, O_PORT_C_DIR, O_PORT_D_DATA, O_PORT_D_DIR;
	logic [7:0] O_PORT_A_FUNC, O_PORT_B_FUNC, O_PULLUP_SEL, O_TIMER0_MODE, O_TIMER0_COMPARE;
	logic [7:0] O_TIMER1_MODE, O_TIMER1_COMPARE, O_PWM_PERIOD, O_PWM_DUTY, O_PWM_HIGH;
	logic [7:0] O_BUZZER_CTRL, O_IRQ_EN_H, O_IRQ_EN_L, O_IRQ_REQ_H, O_IRQ_REQ_L;
	logic [7:0] O_IRQ_EDGE_SEL, O_ADC_MODE, O_CLK_DIV_CTRL, O_WDT_RELOAD, O_POWER_FAIL;
	logic [7:0] ra[6] = '{8'hc0, 8'hc2, 8'hc4, 8'hc6, 8'heb, 8'hed};
	logic [7:0] rv[6] = '{8'h96, 8'h15, 8'h02, 8'h09, 8'h46, 8'h27};
	int miscompares = 0;
	int n_tests = 0;
	dmm_top dut (.*);
	dmm_cpu_model cpu (
		.i_clk(I_MCLK), .i_rst_n(I_NRST), .i_x_inc(O_X_INC), .i_x_ld(xl), .i_x_val(xv),
		.o_sp_wr(I_SP_WR), .o_sp_wdata(I_SP_WDATA), .o_x(I_X)
	);
	initial begin
		I_MCLK = 1'b0;
		forever #25 I_MCLK = ~I_MCLK;
	end
	task chk8(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %0t byte %h not %h", $time, g, e);
		end
	endtask
	task chk16(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %0t word %h not %h", $time, g, e);
		end
	endtask
	task stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// one request, then wait for completion; next request lands a cycle after done
	task go(input logic s, input logic [3:0] m, input logic [1:0] k,
		input logic [7:0] p, input logic [7:0] q, input logic [7:0] d);
		int i;
		@(negedge I_MCLK);
		I_MODE = m;
		I_KIND = k;
		I_STK_KIND = k;
		I_OP1 = p;
		I_OP2 = q;
		I_PC = {p, q};
		I_WDATA = d;
		I_PSW = d;
		I_START = !s;
		I_STK_START = s;
		@(negedge I_MCLK);
		I_START = 1'b0;
		I_STK_START = 1'b0;
		for (i = 0; i < 20 && O_DONE !== 1'b1; i++)
			@(negedge I_MCLK);
		chk8({7'h00, O_DONE}, 8'h01);
	endtask
	task rm(input logic [3:0] m, input logic [7:0] p, input logic [7:0] q);
		go(1'b0, m, `DMM_K_READ, p, q, 8'h00);
	endtask
	task rd(input logic [7:0] p);
		rm(`DMM_MD_DP, p, 8'h00);
	endtask
	task wr(input logic [7:0] p, input logic [7:0] d);
		go(1'b0, `DMM_MD_DP, `DMM_K_WRITE, p, 8'h00, d);
	endtask
	task setx(input logic [7:0] v);
		@(negedge I_MCLK);
		xv <= v;
		xl <= 1'b1;
		@(negedge I_MCLK);
		xl <= 1'b0;
	endtask
	initial begin
		#100000;
		miscompares++;
		stop_test();
	end
	initial begin
		repeat (16) @(negedge I_MCLK);
		I_NRST = 1'b1;
		repeat (4) @(negedge I_MCLK);
		chk8(O_SP, 8'h7f);
		chk8(O_TIMER0_COMPARE, 8'hff);
		chk8(O_ADC_MODE, 8'h01);
		chk8(O_CLK_DIV_CTRL, 8'h17);
		chk8(O_WDT_RELOAD, 8'h7f);
		chk8(O_POWER_FAIL, 8'h04);
		foreach (ra[j]) begin
			rd(ra[j]);
			chk8(O_RDATA, rv[j]);
		end
		wr(8'h7f, 8'h5a);
		rm(`DMM_MD_ABS, 8'h7f, 8'h00);
		chk8(O_RDATA, 8'h5a);
		chk16(O_EA, 16'h007f);
		wr(8'hd1, 8'h3c);
		chk8(O_TIMER0_COMPARE, 8'h3c);
		rd(8'hd1);
		chk8(O_RDATA, 8'h41);
		wr(8'hd0, 8'h20);
		rd(8'hd1);
		chk8(O_RDATA, 8'h42);
		wr(8'hd3, 8'h11);
		chk8(O_TIMER1_COMPARE, 8'h11);
		rd(8'hd4);
		chk8(O_RDATA, 8'h43);
		wr(8'hd2, 8'h10);
		rd(8'hd4);
		chk8(O_RDATA, 8'h44);
		wr(8'hd2, 8'h20);
		wr(8'hd3, 8'h22);
		chk8(O_PWM_PERIOD, 8'h22);
		wr(8'hd4, 8'h33);
		rd(8'hd4);
		chk8(O_RDATA, 8'h33);
		rd(8'hec);
		chk8(O_RDATA, 8'h45);
		wr(8'hec, 8'h05);
		chk8(O_CLK_DIV_CTRL, 8'h05);
		I_BIT = 3'h7;
		go(1'b0, `DMM_MD_DP, `DMM_K_BSET, 8'he2, 8'h00, 8'h00);
		chk8(O_IRQ_EN_H, 8'h80);
		go(1'b0, `DMM_MD_DP, `DMM_K_BSET, 8'hc1, 8'h00, 8'h00);
		chk8(O_PORT_A_DIR, 8'h00);
		go(1'b0, `DMM_MD_DP, `DMM_K_BCLR, 8'he2, 8'h00, 8'h00);
		chk8(O_IRQ_EN_H, 8'h00);
		setx(8'h10);
		go(1'b0, `DMM_MD_XINC, `DMM_K_WRITE, 8'h00, 8'h00, 8'h77);
		@(negedge I_MCLK);
		chk8(I_X, 8'h11);
		setx(8'h10);
		rm(`DMM_MD_XIDX, 8'h00, 8'h00);
		chk8(O_RDATA, 8'h77);
		setx(8'h20);
		rm(`DMM_MD_DPX, 8'hf0, 8'h00);
		chk16(O_EA, 16'h0010);
		I_Y = 8'h08;
		rm(`DMM_MD_DPY, 8'h08, 8'h00);
		chk16(O_EA, 16'h0010);
		wr(8'h20, 8'h0f);
		wr(8'h21, 8'h00);
		setx(8'h08);
		rm(`DMM_MD_XIND, 8'h18, 8'h00);
		chk16(O_EA, 16'h000f);
		I_Y = 8'h01;
		rm(`DMM_MD_INDY, 8'h20, 8'h00);
		chk8(O_RDATA, 8'h77);
		rm(`DMM_MD_ABSIND, 8'h20, 8'h00);
		chk16(O_EA, 16'h000f);
		I_Y = 8'h20;
		rm(`DMM_MD_ABSY, 8'hf0, 8'h00);
		chk16(O_EA, 16'h0110);
		chk8({7'h00, O_EXT}, 8'h01);
		rm(`DMM_MD_REG, 8'h00, 8'h00);
		chk16(O_EA, 16'h0110);
		rm(`DMM_MD_IMM, 8'hc3, 8'h00);
		chk8(O_RDATA, 8'hc3);
		go(1'b1, 4'h0, `DMM_S_CALL, 8'h12, 8'h34, 8'h00);
		chk8(O_SP, 8'h7d);
		rd(8'h7f);
		chk8(O_RDATA, 8'h12);
		rd(8'h7e);
		chk8(O_RDATA, 8'h34);
		go(1'b1, 4'h0, `DMM_S_INT, 8'h56, 8'h78, 8'h9a);
		chk8(O_SP, 8'h7a);
		go(1'b1, 4'h0, `DMM_S_INTERRUPT_RETURN_OP, 8'h00, 8'h00, 8'h00);
		chk16(O_PC, 16'h5678);
		chk8(O_PSW, 8'h9a);
		go(1'b1, 4'h0, `DMM_S_RET, 8'h00, 8'h00, 8'h00);
		chk16(O_PC, 16'h1234);
		chk8(O_SP, 8'h7f);
		stop_test();
	end
endmodule // dmm_top_bench
bind dmm_top dmm_chk u_chk (.*);
`default_nettype wire
